// ===== shared/npic_pkg.sv
/*
 * Constants, types and helpers for the nested interrupt controller.
 * Assumes an APB slave with byte addresses and 32-bit data.
 */
package npic_pkg;
  // ****************************************
  // Sizes and register map
  // ****************************************
  localparam int NVEC = 14;
  localparam int NEXT = 4;
  localparam int NPER = 10;
  localparam logic [7:0] OFS_PRIO0 = 8'h00;
  localparam logic [7:0] OFS_PRIO1 = 8'h04;
  localparam logic [7:0] OFS_PRIO2 = 8'h08;
  localparam logic [7:0] OFS_PRIO3 = 8'h0C;
  localparam logic [7:0] OFS_CC = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h14;
  localparam logic [7:0] OFS_PEND = 8'h18;
  localparam logic [7:0] OFS_PINSEL = 8'h1C;
  localparam logic [7:0] PRIO_RST = 8'hFF;
  localparam logic [3:0] PRIO3_TOP = 4'hF;
  localparam logic [13:0] ENABLE_RST = 14'h0000;
  localparam logic [15:0] PINSEL_RST = 16'hFFFF;
  // ****************************************
  // Priority encodings and vectors
  // ****************************************
  localparam logic [1:0] PRIO_L0 = 2'h2;
  localparam logic [1:0] PRIO_L3 = 2'h3;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_TOP = 16'hFFFA;
  localparam logic [13:0] HALT_WAKE_RST = 14'h013F;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_STACK = 2'h1,
    ST_LOAD = 2'h3
  } npic_state_e;
  typedef struct packed {
    logic instrDone;
    logic stackDone;
    logic enableIrq;
    logic disableIrq;
    logic haltOp;
    logic waitOp;
    logic trapOp;
    logic restoreOp;
    logic [1:0] restorePrio;
  } npic_cpu_op_s;
  // Level 0..3 from a priority pair
  function automatic logic [1:0] prioLevel(input logic [1:0] p);
    case (p)
      2'h2: prioLevel = 2'h0;
      2'h1: prioLevel = 2'h1;
      2'h0: prioLevel = 2'h2;
      default: prioLevel = 2'h3;
    endcase
  endfunction
endpackage

// ===== test/npic_cpu_model.sv
/*
 * CPU sequencer model: reports instruction ends and stacking.
 * Assumes the bench pulses issue for one cycle per instruction.
 */
`timescale 1ns/1ns
module npic_cpu_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bench control
  input wire logic issue,
  input wire npic_pkg::npic_cpu_op_s cmd,
  input wire logic [3:0] lag,
  // Controller side
  input wire logic stackReq,
  output npic_pkg::npic_cpu_op_s cpuOp
);
  logic busyReg;
  logic [3:0] cntReg;
  // ****
  // No instruction ends while stacking is under way
  // ****
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cpuOp <= '0;
      busyReg <= 1'b0;
      cntReg <= 4'h0;
    end else begin
      cpuOp <= '0;
      if (issue && !busyReg) begin
        cpuOp <= cmd;
        cpuOp.instrDone <= 1'b1;
        cpuOp.stackDone <= 1'b0;
      end
      if (stackReq) begin
        busyReg <= 1'b1;
        cntReg <= lag;
      end else if (busyReg && cntReg == 4'h0) begin
        cpuOp.stackDone <= 1'b1;
        busyReg <= 1'b0;
      end else if (busyReg) begin
        cntReg <= cntReg - 4'h1;
      end
    end
  end
endmodule

// ===== test/npic_top_tb_top.sv
/*
 * Self-checking bench for npic_top with a CPU sequencer model.
 * Assumes the default halt-wake set and the package register map.
 */
`timescale 1ns/1ns
module npic_top_tb_top;
  localparam logic [5:0] NOP = 6'h00;
  localparam logic [5:0] EN = 6'h20;
  localparam logic [5:0] HLT = 6'h08;
  localparam logic [5:0] WT = 6'h04;
  localparam logic [5:0] TRP = 6'h02;
  localparam logic [5:0] RET = 6'h01;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, stackReq, vecLoad, levelMasked, cpuHalted, cpuWaiting, err;
  logic [15:0] vecAddr;
  logic [1:0] ccPrio;
  npic_pkg::npic_cpu_op_s cpuOp;
  npic_pkg::npic_cpu_op_s cmd = '0;
  logic issue = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [15:0] extPins = 16'h0;
  logic [9:0] perFlag = 10'h0;
  logic [9:0] perEnable = 10'h0;
  logic [9:0] perClear = 10'h0;
  logic [15:0] lastVec = 16'h0;
  logic [1:0] lastPrio = 2'h0;
  int miscompares = 0;
  int totalChecks = 0;
  int entries = 0;
  int stacks = 0;
  int mark = 0;
  int cycles = 0;
  int s0;

  always #20 mclk = ~mclk;

  npic_top dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuOp(cpuOp), .stackReq(stackReq),
    .vecLoad(vecLoad), .vecAddr(vecAddr), .ccPrio(ccPrio), .levelMasked(levelMasked), .cpuHalted(cpuHalted),
    .cpuWaiting(cpuWaiting), .extPins(extPins), .perFlag(perFlag), .perEnable(perEnable), .perClear(perClear));

  npic_cpu_model cpu (.mclk(mclk), .nrst(nrst), .issue(issue), .cmd(cmd), .lag(lag), .stackReq(stackReq),
    .cpuOp(cpuOp));

  // ****
  // Entry monitor and timeout
  // ****
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (vecLoad === 1'b1) begin
      entries <= entries + 1;
      lastVec <= vecAddr;
      lastPrio <= ccPrio;
    end
    if (stackReq === 1'b1) stacks <= stacks + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic step(input logic [5:0] f, input logic [1:0] p);
    cmd <= npic_pkg::npic_cpu_op_s'({2'b00, f, p});
    issue <= 1'b1;
    @(posedge mclk);
    issue <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic expEntry(input logic [15:0] v, input logic [1:0] p);
    while (entries == mark) @(posedge mclk);
    chk({16'h0, lastVec}, {16'h0, v});
    chk({30'h0, lastPrio}, {30'h0, p});
    mark = entries;
  endtask

  task automatic noEntry();
    repeat (12) @(posedge mclk);
    chk(entries, mark);
  endtask

  task automatic clr(input logic [9:0] m);
    perFlag <= perFlag & ~m;
    perClear <= m;
    @(posedge mclk);
    perClear <= 10'h0;
    @(posedge mclk);
  endtask

  task automatic pend(input logic [31:0] exp);
    apb(1'b0, npic_pkg::OFS_PEND, 32'h0);
    chk(rd, exp);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic testRegs();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, npic_pkg::OFS_PRIO0 + 8'(4 * i), 32'h0);
      chk(rd, 32'h0000_00FF);
    end
    apb(1'b1, npic_pkg::OFS_PRIO3, 32'h0);
    apb(1'b0, npic_pkg::OFS_PRIO3, 32'h0);
    chk(rd, 32'h0000_00F0);
    apb(1'b1, npic_pkg::OFS_PRIO0, 32'h0000_00CF);
    apb(1'b1, npic_pkg::OFS_PRIO0, 32'h0000_0064);
    apb(1'b0, npic_pkg::OFS_PRIO0, 32'h0);
    chk(rd, 32'h0000_0044);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic testArb();
    apb(1'b1, npic_pkg::OFS_ENABLE, 32'h0000_3FFF);
    perEnable <= 10'h3EF;
    perFlag <= 10'h013;
    step(NOP, 2'h0);
    noEntry();
    pend(32'h0000_0003);
    step(EN, 2'h0);
    chk({30'h0, ccPrio}, 32'h2);
    step(NOP, 2'h0);
    expEntry(16'hFFFA, 2'h0);
    clr(10'h001);
    step(NOP, 2'h0);
    noEntry();
    step(RET, 2'h2);
    step(NOP, 2'h0);
    expEntry(16'hFFF8, 2'h1);
    clr(10'h002);
    perFlag <= 10'h01C;
    step(NOP, 2'h0);
    expEntry(16'hFFEE, 2'h3);
    clr(10'h00C);
  endtask

  task automatic testClearTrap();
    perFlag <= perFlag | 10'h020;
    pend(32'h0000_0200);
    clr(10'h020);
    pend(32'h0);
    lag <= 4'h5;
    s0 = stacks;
    step(TRP, 2'h0);
    expEntry(npic_pkg::VEC_TRAP, npic_pkg::PRIO_L3);
    chk(stacks, s0 + 1);
  endtask

  task automatic testExt();
    step(RET, 2'h2);
    chk({30'h0, ccPrio}, 32'h2);
    chk({31'h0, levelMasked}, 32'h0);
    extPins <= 16'h0002;
    step(NOP, 2'h0);
    expEntry(16'hFFF6, 2'h0);
    pend(32'h0);
    extPins <= 16'h0;
  endtask

  task automatic testLowPower();
    step(RET, 2'h2);
    step(WT, 2'h0);
    chk({31'h0, cpuWaiting}, 32'h1);
    perFlag <= perFlag | 10'h001;
    repeat (4) @(posedge mclk);
    chk({31'h0, cpuWaiting}, 32'h0);
    step(NOP, 2'h0);
    expEntry(16'hFFFA, 2'h0);
    clr(10'h001);
    step(RET, 2'h2);
    step(HLT, 2'h0);
    perFlag <= perFlag | 10'h004;
    repeat (10) @(posedge mclk);
    chk({31'h0, cpuHalted}, 32'h1);
    extPins <= 16'h0001;
    repeat (4) @(posedge mclk);
    chk({31'h0, cpuHalted}, 32'h0);
    step(NOP, 2'h0);
    expEntry(16'hFFF6, 2'h0);
    step(NOP, 2'h0);
    expEntry(16'hFFEE, 2'h3);
    extPins <= 16'h0;
    clr(10'h004);
  endtask

  task automatic testReentry();
    step(RET, 2'h2);
    perFlag <= perFlag | 10'h001;
    step(NOP, 2'h0);
    expEntry(16'hFFFA, 2'h0);
    noEntry();
    apb(1'b1, npic_pkg::OFS_PRIO0, 32'h0000_0047);
    step(NOP, 2'h0);
    expEntry(16'hFFFA, 2'h3);
    clr(10'h001);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    expEntry(npic_pkg::VEC_RESET, npic_pkg::PRIO_L3);
    chk(stacks, 0);
    chk({31'h0, levelMasked}, 32'h1);
    testRegs();
    testArb();
    testClearTrap();
    testExt();
    testLowPower();
    testReentry();
    tally_and_finish();
  end
endmodule

// ===== verilog/npic_arbiter.sv
/*
 * Combinational arbiter: highest level wins, lower index breaks ties.
 * Assumes requests already gated by enables.
 */
`timescale 1ns/1ns
module npic_arbiter #(
  parameter int N = 14
) (
  // Requests
  input wire logic [N-1:0] req,
  input wire logic [2*N-1:0] prio,
  input wire logic [1:0] curLevel,
  // Winner
  output logic found,
  output logic [3:0] idx
);
  logic [1:0] best;
  logic [1:0] lv;
  always_comb begin
    found = 1'b0;
    idx = 4'h0;
    best = 2'h0;
    lv = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      lv = npic_pkg::prioLevel(prio[2*i +: 2]);
      if (req[i] && lv > curLevel && (!found || lv >= best)) begin
        found = 1'b1;
        idx = 4'(i);
        best = lv;
      end
    end
  end
endmodule

// ===== verilog/npic_ext_line.sv
/*
 * One external interrupt line: selected pins ORed, rising edge latched.
 * Assumes pins synchronous to mclk.
 */
`timescale 1ns/1ns
module npic_ext_line #(
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pins and control
  input wire logic [PINS-1:0] pins,
  input wire logic [PINS-1:0] pinSel,
  input wire logic clr,
  // Request
  output logic req
);
  logic lvl_reg, lvl_next, req_reg, req_next;
  always_comb begin
    lvl_next = |(pins & pinSel);
    req_next = (lvl_next & ~lvl_reg) | (req_reg & ~clr);
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lvl_reg <= 1'b0;
      req_reg <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
      req_reg <= req_next;
    end
  end
  assign req = req_reg;
endmodule

// ===== verilog/npic_top.sv
/*
 * Nested interrupt controller: APB registers, request latches,
 * arbitration, entry sequence and low power wake.
 * Assumes the CPU sequencer reports instruction ends and stacking.
 */
`timescale 1ns/1ns
module npic_top #(
  parameter int PINS = 4,
  parameter logic [13:0] HALT_WAKE = npic_pkg::HALT_WAKE_RST
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU sequencer
  input wire npic_pkg::npic_cpu_op_s cpuOp,
  output logic stackReq,
  output logic vecLoad,
  output logic [15:0] vecAddr,
  output logic [1:0] ccPrio,
  output logic levelMasked,
  output logic cpuHalted,
  output logic cpuWaiting,
  // Sources
  input wire logic [npic_pkg::NEXT*PINS-1:0] extPins,
  input wire logic [npic_pkg::NPER-1:0] perFlag,
  input wire logic [npic_pkg::NPER-1:0] perEnable,
  input wire logic [npic_pkg::NPER-1:0] perClear
);
  localparam int NV = npic_pkg::NVEC;
  // ****************************************
  // State
  // ****************************************
  npic_pkg::npic_state_e st_reg, st_next;
  logic [2*NV-1:0] prio_reg, prio_next;
  logic [13:0] en_reg, en_next;
  logic [15:0] pinSel_reg, pinSel_next;
  logic [1:0] cc_reg, cc_next;
  localparam int NPER_W = npic_pkg::NPER;
  logic [NPER_W-1:0] perLat_reg, perLat_next;
  logic resetPend_reg, resetPend_next;
  logic isTrap_reg, isTrap_next;
  logic [3:0] idx_reg, idx_next;
  logic haltFirst_reg, haltFirst_next;
  logic halted_reg, halted_next;
  logic waiting_reg, waiting_next;
  logic stackReq_reg, stackReq_next;
  logic vecLoad_reg, vecLoad_next;
  logic [15:0] vec_reg, vec_next;
  logic [1:0] lastPrio_reg, lastPrio_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  // ****************************************
  // Sources
  // ****************************************
  logic [NPER_W-1:0] perReq;
  logic [3:0] extReq;
  logic [3:0] extClr;
  logic [NV-1:0] reqAll, reqElig;
  logic found;
  logic [3:0] winIdx;
  for (genvar g = 0; g < 4; g++) begin : gExt
    npic_ext_line #(.PINS(PINS)) uLine (
      .mclk(mclk),
      .nrst(nrst),
      .pins(extPins[g*PINS +: PINS]),
      .pinSel(pinSel_reg[g*4 +: PINS]),
      .clr(extClr[g]),
      .req(extReq[g])
    );
  end
  always_comb begin
    perLat_next = (perFlag & perEnable) | (perLat_reg & ~perClear);
    perReq = perLat_reg & perFlag & perEnable;
    reqAll = {perReq[9:2], extReq, perReq[1:0]};
    reqElig = reqAll & en_reg & (haltFirst_reg ? HALT_WAKE : 14'h3FFF);
  end
  npic_arbiter #(.N(NV)) uArb (
    .req(reqElig),
    .prio(prio_reg),
    .curLevel(npic_pkg::prioLevel(cc_reg)),
    .found(found),
    .idx(winIdx)
  );
  // ****************************************
  // APB registers
  // ****************************************
  logic apbWr, apbAcc;
  logic [7:0] wb, ob;
  always_comb begin
    apbAcc = psel & penable & ~pready_reg;
    apbWr = psel & penable & pready_reg & pwrite;
    prio_next = prio_reg;
    en_next = en_reg;
    pinSel_next = pinSel_reg;
    wb = pwdata[7:0];
    ob = 8'h00;
    pready_next = apbAcc;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (apbWr) begin
      case (paddr)
        npic_pkg::OFS_PRIO0, npic_pkg::OFS_PRIO1, npic_pkg::OFS_PRIO2, npic_pkg::OFS_PRIO3: begin
          ob = 8'(prio_reg >> (paddr[3:2] * 8));
          for (int k = 0; k < 4; k++) begin
            if (wb[2*k +: 2] != npic_pkg::PRIO_L0) begin
              ob[2*k +: 2] = wb[2*k +: 2];
            end
          end
          if (paddr == npic_pkg::OFS_PRIO3) begin
            prio_next[24 +: 4] = ob[3:0];
          end else begin
            prio_next[paddr[3:2]*8 +: 8] = ob;
          end
        end
        npic_pkg::OFS_ENABLE: en_next = pwdata[13:0];
        npic_pkg::OFS_PINSEL: pinSel_next = pwdata[15:0];
        default: ;
      endcase
    end
    if (apbAcc) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        npic_pkg::OFS_PRIO0: prdata_next[7:0] = prio_reg[7:0];
        npic_pkg::OFS_PRIO1: prdata_next[7:0] = prio_reg[15:8];
        npic_pkg::OFS_PRIO2: prdata_next[7:0] = prio_reg[23:16];
        npic_pkg::OFS_PRIO3: prdata_next[7:0] = {npic_pkg::PRIO3_TOP, prio_reg[27:24]};
        npic_pkg::OFS_CC: prdata_next[7:0] = {2'h3, cc_reg[1], 1'b0, cc_reg[0], 3'h0};
        npic_pkg::OFS_ENABLE: prdata_next[13:0] = en_reg;
        npic_pkg::OFS_PEND: prdata_next[13:0] = reqAll;
        npic_pkg::OFS_PINSEL: prdata_next[15:0] = pinSel_reg;
        default: pslverr_next = 1'b1;
      endcase
    end
  end
  // ****************************************
  // Entry sequence and current level
  // ****************************************
  logic wakeAny, wakeHalt;
  always_comb begin
    st_next = st_reg;
    cc_next = cc_reg;
    resetPend_next = resetPend_reg;
    isTrap_next = isTrap_reg;
    idx_next = idx_reg;
    haltFirst_next = haltFirst_reg;
    halted_next = halted_reg;
    waiting_next = waiting_reg;
    stackReq_next = 1'b0;
    vecLoad_next = 1'b0;
    vec_next = vec_reg;
    lastPrio_next = lastPrio_reg;
    extClr = 4'h0;
    wakeAny = |(reqAll & en_reg);
    wakeHalt = |(reqAll & en_reg & HALT_WAKE);
    if (waiting_reg && wakeAny) begin
      waiting_next = 1'b0;
    end
    if (halted_reg && wakeHalt) begin
      halted_next = 1'b0;
      haltFirst_next = 1'b1;
    end
    case (st_reg)
      npic_pkg::ST_IDLE: begin
        if (resetPend_reg) begin
          st_next = npic_pkg::ST_LOAD;
        end else if (cpuOp.instrDone && !halted_reg && !waiting_reg) begin
          if (cpuOp.trapOp) begin
            isTrap_next = 1'b1;
            st_next = npic_pkg::ST_STACK;
            stackReq_next = 1'b1;
          end else if (found) begin
            isTrap_next = 1'b0;
            idx_next = winIdx;
            st_next = npic_pkg::ST_STACK;
            stackReq_next = 1'b1;
          end else if (cpuOp.enableIrq) begin
            cc_next = npic_pkg::PRIO_L0;
          end else if (cpuOp.disableIrq) begin
            cc_next = npic_pkg::PRIO_L3;
          end else if (cpuOp.haltOp) begin
            cc_next = npic_pkg::PRIO_L0;
            halted_next = 1'b1;
          end else if (cpuOp.waitOp) begin
            cc_next = npic_pkg::PRIO_L0;
            waiting_next = 1'b1;
          end else if (cpuOp.restoreOp) begin
            cc_next = cpuOp.restorePrio;
          end
        end
      end
      npic_pkg::ST_STACK: begin
        if (cpuOp.stackDone) begin
          st_next = npic_pkg::ST_LOAD;
        end
      end
      npic_pkg::ST_LOAD: begin
        st_next = npic_pkg::ST_IDLE;
        vecLoad_next = 1'b1;
        if (resetPend_reg) begin
          resetPend_next = 1'b0;
          vec_next = npic_pkg::VEC_RESET;
          cc_next = npic_pkg::PRIO_L3;
        end else if (isTrap_reg) begin
          vec_next = npic_pkg::VEC_TRAP;
          cc_next = npic_pkg::PRIO_L3;
        end else begin
          vec_next = npic_pkg::VEC_TOP - {11'h000, idx_reg, 1'b0};
          cc_next = prio_reg[2*idx_reg +: 2];
          lastPrio_next = prio_reg[2*idx_reg +: 2];
          haltFirst_next = 1'b0;
          if (idx_reg >= 4'h2 && idx_reg <= 4'h5) begin
            extClr[idx_reg[1:0] - 2'h2] = 1'b1;
          end
        end
      end
      default: st_next = npic_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= npic_pkg::ST_IDLE;
      prio_reg <= {npic_pkg::PRIO3_TOP, {3{npic_pkg::PRIO_RST}}};
      en_reg <= npic_pkg::ENABLE_RST;
      pinSel_reg <= npic_pkg::PINSEL_RST;
      cc_reg <= npic_pkg::PRIO_L3;
      perLat_reg <= '0;
      resetPend_reg <= 1'b1;
      isTrap_reg <= 1'b0;
      idx_reg <= 4'h0;
      haltFirst_reg <= 1'b0;
      halted_reg <= 1'b0;
      waiting_reg <= 1'b0;
      stackReq_reg <= 1'b0;
      vecLoad_reg <= 1'b0;
      vec_reg <= npic_pkg::VEC_RESET;
      lastPrio_reg <= npic_pkg::PRIO_L3;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      prio_reg <= prio_next;
      en_reg <= en_next;
      pinSel_reg <= pinSel_next;
      cc_reg <= cc_next;
      perLat_reg <= perLat_next;
      resetPend_reg <= resetPend_next;
      isTrap_reg <= isTrap_next;
      idx_reg <= idx_next;
      haltFirst_reg <= haltFirst_next;
      halted_reg <= halted_next;
      waiting_reg <= waiting_next;
      stackReq_reg <= stackReq_next;
      vecLoad_reg <= vecLoad_next;
      vec_reg <= vec_next;
      lastPrio_reg <= lastPrio_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  logic masked_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      masked_reg <= 1'b1;
    end else begin
      masked_reg <= (cc_next == npic_pkg::PRIO_L3);
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign stackReq = stackReq_reg;
  assign vecLoad = vecLoad_reg;
  assign vecAddr = vec_reg;
  assign ccPrio = cc_reg;
  assign levelMasked = masked_reg;
  assign cpuHalted = halted_reg;
  assign cpuWaiting = waiting_reg;
  // ****************************************
  // Checks
  // ****************************************
  logic anyL0;
  always_comb begin
    anyL0 = 1'b0;
    for (int k = 0; k < NV; k++) begin
      anyL0 = anyL0 | (prio_reg[2*k +: 2] == npic_pkg::PRIO_L0);
    end
  end
  sequence sTrapStack;
    stackReq && isTrap_reg ##[1:300] st_reg == npic_pkg::ST_LOAD;
  endsequence
  sequence sLevel3Load;
    ##1 vecLoad && vecAddr == npic_pkg::VEC_TRAP && ccPrio == npic_pkg::PRIO_L3;
  endsequence
  AST_TAKE_AT_END: assert property (@(posedge mclk) disable iff (!nrst)
    stackReq |-> $past(cpuOp.instrDone)) else $error("entry not at end of instruction");
  AST_TRAP_LEVEL3: assert property (@(posedge mclk) disable iff (!nrst)
    sTrapStack |-> sLevel3Load) else $error("trap entry did not set level 3");
  AST_PAIR_L0: assert property (@(posedge mclk) disable iff (!nrst)
    !anyL0) else $error("priority pair holds level 0 pattern");
  AST_PRIO3_TOP: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pready) && !pwrite && paddr == npic_pkg::OFS_PRIO3 |-> prdata[7:4] == 4'hF)
    else $error("upper nibble of last priority register not ones");
  AST_ENABLE_L0: assert property (@(posedge mclk) disable iff (!nrst)
    st_reg == npic_pkg::ST_IDLE && !resetPend_reg && cpuOp.instrDone && cpuOp.enableIrq && !cpuOp.trapOp
    && !found && !halted_reg && !waiting_reg |=> ccPrio == npic_pkg::PRIO_L0 && !levelMasked)
    else $error("enable instruction did not load level 0");
  AST_ENTRY_LEVEL: assert property (@(posedge mclk) disable iff (!nrst)
    vecLoad && vecAddr <= npic_pkg::VEC_TOP |-> ccPrio == lastPrio_reg)
    else $error("entry level differs from stored pair");
  AST_HALT_WAKE: assert property (@(posedge mclk) disable iff (!nrst)
    cpuHalted && |(reqAll & en_reg & HALT_WAKE) |=> !cpuHalted && haltFirst_reg)
    else $error("halt-capable request did not wake");
  AST_MASKED_ENTRY: assert property (@(posedge mclk) disable iff (!nrst)
    stackReq && !isTrap_reg |-> npic_pkg::prioLevel(prio_reg[2*idx_reg +: 2]) > npic_pkg::prioLevel($past(cc_reg)))
    else $error("maskable entry without level above current");
  AST_RESET_FIRST: assert property (@(posedge mclk) disable iff (!nrst)
    resetPend_reg ##1 resetPend_reg |=> vecLoad && vecAddr == npic_pkg::VEC_RESET && ccPrio == npic_pkg::PRIO_L3)
    else $error("reset vector not loaded first at level 3");
endmodule
